// file: sbc_top.sv
// smbus slave with identity registers, read length register and straps
//
// Function
// - index 5 is read only, vendor code in bits 0-3, revision in bits 4-7.
// - index 6 is a read only fixed device code, bit 7 the msb.
// - index 7 bits 0-4 are writable and set the block read byte count.
// - index 7 resets to a count of eight, bits 5-7 read as zero.
// - frequency strap high picks 100 MHz, low picks 133 MHz.
// - bandwidth strap high, middle, low pick high bw, bypass, low bw.
// - power input high makes the part active, low powers it down.
// - the two tri-level address straps select the slave address.
// - the data line is only pulled low or released, never driven high.
// - the part is a slave and only receives the serial clock.
// - a block command has msb clear, low seven bits the start index.
// - a block read first sends a count from 1 to 31, then the data.
`timescale 1ns/1ns
`default_nettype none
`include "sbc_map.svh"
module sbc_top #(
  parameter logic [3:0] VENDOR_ID = 4'hA,   // arbitrary value
  parameter logic [3:0] REVISION = 4'h3,    // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h5C   // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  input wire logic frequency_select_strap,
  input wire logic [1:0] pll_bandwidth_strap,
  input wire logic power_good_down_input,
  input wire logic [1:0] slave_addr_strap_low,
  input wire logic [1:0] slave_addr_strap_high,
  output logic freq_is_100m,
  output sbc_pkg::sbc_pll_mode_t pll_mode,
  output logic power_active,
  output logic [6:0] slave_addr,
  output logic [4:0] read_length
);
  logic scl_s, sda_s, freq_s, pwr_s;
  logic [1:0] pll_s, sal_s, sah_s;
  logic scl_d, sda_d, next_scl_d, next_sda_d;
  logic start, stop, scl_rise, scl_fall;
  sbc_pkg::sbc_state_t st, next_st, after, next_after;
  logic [7:0] sh, next_sh;
  logic [3:0] bitcnt, next_bitcnt;
  logic [6:0] idx, next_idx;
  logic [5:0] left, next_left;
  logic byte_mode, next_byte_mode, send_cnt, next_send_cnt;
  logic macked, next_macked, drive, next_drive;
  logic [4:0] next_read_length;
  logic wr_ok, wr_len;
  logic strap_done, next_strap_done, next_freq, next_power;
  logic strap_take;
  logic [1:0] strap_age, next_strap_age;
  sbc_pkg::sbc_pll_mode_t next_pll;
  logic [6:0] next_slave_addr;
  logic [7:0] count_byte, cur_byte;

  sbc_sync #(.W(10)) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .din({scl_i, sda_i, frequency_select_strap, pll_bandwidth_strap,
          power_good_down_input, slave_addr_strap_low,
          slave_addr_strap_high}),
    .dout({scl_s, sda_s, freq_s, pll_s, pwr_s, sal_s, sah_s})
  );

  function automatic logic [1:0] tri_val(input logic [1:0] code);
    if (code == `SBC_TRI_LOW) tri_val = 2'h0;
    else if (code == `SBC_TRI_MID) tri_val = 2'h1;
    else tri_val = 2'h2;
  endfunction : tri_val

  function automatic logic [7:0] reg_byte(input logic [6:0] i);
    case (i)
      `SBC_IDX_VENREV: reg_byte = {REVISION, VENDOR_ID};
      `SBC_IDX_DEVID: reg_byte = DEVICE_ID;
      `SBC_IDX_RDLEN: reg_byte = {3'h0, read_length};
      default: reg_byte = 8'h00;
    endcase
  endfunction : reg_byte

  // edges of the host driven clock, sampled only
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start = scl_s & scl_d & sda_d & ~sda_s;
  assign stop = scl_s & scl_d & ~sda_d & sda_s;
  // count of zero would break the block read, so send one instead
  assign count_byte = (read_length == 5'h00) ? {3'h0, `SBC_LEN_MIN} :
                      {3'h0, read_length};
  assign cur_byte = reg_byte(idx);
  assign wr_ok = byte_mode | (left != 6'h00);
  assign wr_len = ce & ~start & ~stop & (st == sbc_pkg::st_wdata) &
                  scl_fall & (bitcnt == `SBC_BYTE_BITS) & wr_ok &
                  (idx == `SBC_IDX_RDLEN);
  assign sda_o = 1'b0;
  assign sda_oe_n = ~drive;

  always_comb begin
    next_scl_d = scl_s;
    next_sda_d = sda_s;
    next_st = st;
    next_after = after;
    next_sh = sh;
    next_bitcnt = bitcnt;
    next_idx = idx;
    next_left = left;
    next_byte_mode = byte_mode;
    next_send_cnt = send_cnt;
    next_macked = macked;
    next_drive = drive;
    next_read_length = read_length;
    if (wr_len) next_read_length = sh[4:0];
    if (start) begin
      next_st = sbc_pkg::st_addr;
      next_bitcnt = 4'h0;
      next_drive = 1'b0;
    end else if (stop) begin
      next_st = sbc_pkg::st_idle;
      next_drive = 1'b0;
    end else begin
      case (st)
        sbc_pkg::st_idle: begin
          next_drive = 1'b0;
        end
        sbc_pkg::st_addr, sbc_pkg::st_cmd, sbc_pkg::st_wcnt,
        sbc_pkg::st_wdata: begin
          if (scl_rise && bitcnt < `SBC_BYTE_BITS) begin
            next_sh = {sh[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (scl_fall && bitcnt == `SBC_BYTE_BITS) begin
            next_bitcnt = 4'h0;
            next_st = sbc_pkg::st_ack;
            next_drive = 1'b1;
            next_after = sbc_pkg::st_wdata;
            case (st)
              sbc_pkg::st_addr: begin
                if (sh[7:1] != slave_addr) begin
                  next_st = sbc_pkg::st_idle;
                  next_drive = 1'b0;
                end else if (sh[0]) begin
                  next_after = sbc_pkg::st_rdata;
                  next_send_cnt = ~byte_mode;
                end else begin
                  next_after = sbc_pkg::st_cmd;
                end
              end
              sbc_pkg::st_cmd: begin
                next_idx = sh[6:0];
                next_byte_mode = sh[`SBC_CMD_BYTE_BIT];
                next_after = sh[`SBC_CMD_BYTE_BIT] ? sbc_pkg::st_wdata :
                             sbc_pkg::st_wcnt;
              end
              sbc_pkg::st_wcnt: begin
                next_left = (sh > `SBC_LEN_MAX) ? 6'h00 : sh[5:0];
              end
              default: begin
                if (wr_ok) begin
                  next_idx = idx + 7'h01;
                  if (!byte_mode) next_left = left - 6'h01;
                end
              end
            endcase
          end
        end
        sbc_pkg::st_ack: begin
          if (scl_fall) begin
            next_st = after;
            next_drive = 1'b0;
            if (after == sbc_pkg::st_rdata) begin
              next_sh = send_cnt ? count_byte : cur_byte;
              next_drive = send_cnt ? ~count_byte[7] : ~cur_byte[7];
              next_bitcnt = 4'h1;
            end
          end
        end
        sbc_pkg::st_rdata: begin
          if (scl_fall) begin
            if (bitcnt < `SBC_BYTE_BITS) begin
              next_sh = {sh[6:0], 1'b0};
              next_drive = ~sh[6];
              next_bitcnt = bitcnt + 4'h1;
            end else begin
              next_drive = 1'b0;
              next_st = sbc_pkg::st_mack;
            end
          end
        end
        sbc_pkg::st_mack: begin
          if (scl_rise) begin
            next_macked = ~sda_s;
          end else if (scl_fall) begin
            if (macked) begin
              next_st = sbc_pkg::st_rdata;
              next_bitcnt = 4'h1;
              next_send_cnt = 1'b0;
              next_idx = send_cnt ? idx : idx + 7'h01;
              next_sh = reg_byte(next_idx);
              next_drive = ~next_sh[7];
            end else begin
              next_st = sbc_pkg::st_idle;
            end
          end
        end
        default: begin
          next_st = sbc_pkg::st_idle;
          next_drive = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_d <= 1'b0;
      sda_d <= 1'b0;
      st <= sbc_pkg::st_idle;
      after <= sbc_pkg::st_idle;
      sh <= 8'h00;
      bitcnt <= 4'h0;
      idx <= 7'h00;
      left <= 6'h00;
      byte_mode <= 1'b0;
      send_cnt <= 1'b0;
      macked <= 1'b0;
      drive <= 1'b0;
      read_length <= `SBC_LEN_RESET;
    end else if (ce) begin
      scl_d <= next_scl_d;
      sda_d <= next_sda_d;
      st <= next_st;
      after <= next_after;
      sh <= next_sh;
      bitcnt <= next_bitcnt;
      idx <= next_idx;
      left <= next_left;
      byte_mode <= next_byte_mode;
      send_cnt <= next_send_cnt;
      macked <= next_macked;
      drive <= next_drive;
      read_length <= next_read_length;
    end
  end

  // straps caught once after reset release, power input followed live
  // synchroniser is cleared by reset, so wait until it holds the pins
  assign strap_take = ~strap_done & (strap_age == `SBC_STRAP_WAIT);

  always_comb begin
    next_strap_done = strap_done | strap_take;
    next_strap_age = strap_age;
    next_freq = freq_is_100m;
    next_pll = pll_mode;
    next_slave_addr = slave_addr;
    next_power = pwr_s;
    if (!strap_done) next_strap_age = strap_age + 2'h1;
    if (strap_take) begin
      next_freq = freq_s;
      case (tri_val(pll_s))
        2'h0: next_pll = sbc_pkg::pll_low_bw;
        2'h1: next_pll = sbc_pkg::pll_bypass;
        default: next_pll = sbc_pkg::pll_high_bw;
      endcase
      next_slave_addr = `SBC_ADDR_BASE + 7'(tri_val(sah_s)) * 7'h03 +
                        7'(tri_val(sal_s));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_done <= 1'b0;
      strap_age <= 2'h0;
      freq_is_100m <= 1'b0;
      pll_mode <= sbc_pkg::pll_low_bw;
      slave_addr <= `SBC_ADDR_BASE;
      power_active <= 1'b0;
    end else if (ce) begin
      strap_done <= next_strap_done;
      strap_age <= next_strap_age;
      freq_is_100m <= next_freq;
      pll_mode <= next_pll;
      slave_addr <= next_slave_addr;
      power_active <= next_power;
    end
  end

  a_sda_pull_only: assert property (@(posedge clk) disable iff (!rst_n)
    !sda_oe_n |-> (st == sbc_pkg::st_ack || st == sbc_pkg::st_rdata))
    else $error("data line pulled outside ack or send");
  a_vendor_rev_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !start && !stop && st == sbc_pkg::st_ack && scl_fall &&
     after == sbc_pkg::st_rdata && !send_cnt &&
     idx == `SBC_IDX_VENREV) |=> sh == {REVISION, VENDOR_ID})
    else $error("vendor revision byte not loaded");
  a_device_id_fixed: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !start && !stop && st == sbc_pkg::st_ack && scl_fall &&
     after == sbc_pkg::st_rdata && !send_cnt &&
     idx == `SBC_IDX_DEVID) |=> sh == DEVICE_ID)
    else $error("device id byte not loaded");
  a_len_reset_val: assert property (@(posedge clk)
    !rst_n |=> read_length == `SBC_LEN_RESET)
    else $error("read length not eight after reset");
  a_len_write_take: assert property (@(posedge clk) disable iff (!rst_n)
    wr_len |=> read_length == $past(sh[4:0]))
    else $error("read length write lost");
  a_len_hold_ro: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_len |=> $stable(read_length))
    else $error("read length changed without write");
  a_count_in_range: assert property (@(posedge clk) disable iff (!rst_n)
    count_byte >= 8'h01 && count_byte <= `SBC_LEN_MAX)
    else $error("block count out of range");
  a_cmd_sets_index: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && !start && !stop && st == sbc_pkg::st_cmd && scl_fall &&
     bitcnt == `SBC_BYTE_BITS) |=> idx == $past(sh[6:0]))
    else $error("command byte did not set index");
  a_freq_latched: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && strap_take) |=> freq_is_100m == $past(freq_s))
    else $error("frequency strap not latched");
  a_power_follow: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> power_active == $past(pwr_s))
    else $error("power state does not follow input");
  a_pll_bypass_mid: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && strap_take && pll_s == `SBC_TRI_MID) |=>
    pll_mode == sbc_pkg::pll_bypass)
    else $error("middle strap not bypass");
endmodule : sbc_top
`default_nettype wire

// file: sbc_map.svh
// register offsets, field positions, reset values and strap codes
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH
`define SBC_IDX_VENREV 7'h05
`define SBC_IDX_DEVID 7'h06
`define SBC_IDX_RDLEN 7'h07
`define SBC_VEN_LSB 0
`define SBC_REV_LSB 4
`define SBC_LEN_W 5
`define SBC_LEN_RESET 5'h08
`define SBC_LEN_MIN 5'h01
`define SBC_LEN_MAX 8'h20
`define SBC_CMD_BYTE_BIT 7
`define SBC_TRI_LOW 2'h0
`define SBC_TRI_MID 2'h1
`define SBC_ADDR_BASE 7'h68
`define SBC_BYTE_BITS 4'h8
`define SBC_STRAP_WAIT 2'h2
`endif

// file: sbc_pkg.sv
// types shared by the strap and register bank logic
package sbc_pkg;
  typedef enum logic [2:0] {
    st_idle, st_addr, st_cmd, st_wcnt, st_wdata, st_ack, st_rdata, st_mack
  } sbc_state_t;
  typedef enum logic [1:0] {
    pll_low_bw, pll_bypass, pll_high_bw
  } sbc_pll_mode_t;
endpackage : sbc_pkg

// file: sbc_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ns
`default_nettype none
module sbc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_dout;

  always_comb begin
    next_meta = meta;
    next_dout = dout;
    if (ce) begin
      next_meta = din;
      next_dout = meta;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= next_meta;
      dout <= next_dout;
    end
  end
endmodule : sbc_sync
`default_nettype wire

// file: sbc_host.sv
// smbus host model that drives the clock and the open drain data line
`timescale 1ns/1ns
`default_nettype none
module sbc_host (
  input wire logic clk,
  input wire logic sda_w,
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'b1;
    sda = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk
  // host makes every clock pulse, idle high
  task automatic drv(input logic c, input logic d);
    tk(3);
    scl <= c;
    sda <= d;
  endtask : drv
  task automatic start();
    drv(scl, 1'b1);
    drv(1'b1, 1'b1);
    drv(1'b1, 1'b0);
    drv(1'b0, 1'b0);
  endtask : start
  task automatic stop();
    drv(1'b0, 1'b0);
    drv(1'b1, 1'b0);
    drv(1'b1, 1'b1);
  endtask : stop
  task automatic bit_x(input logic b, output logic r);
    drv(1'b0, b);
    drv(1'b1, b);
    tk(3);
    r = sda_w;
    drv(1'b0, b);
  endtask : bit_x
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wbyte
  task automatic rbyte(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nak, r);
  endtask : rbyte
endmodule : sbc_host
`default_nettype wire

// file: testbench.sv
// self-checking bench for the smbus register and strap block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst_n, freq, pwr, sda_o, sda_oe_n, scl, sda_h, f100, pa;
  logic [1:0] pll, a_lo, a_hi;
  logic [6:0] slave_addr, dev_addr;
  logic [4:0] read_length;
  sbc_pkg::sbc_pll_mode_t pll_mode;
  int mismatches = 0;
  int samples_checked = 0;
  wire sda_w = sda_h & (sda_oe_n | sda_o);
  sbc_top uut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .frequency_select_strap(freq),
    .pll_bandwidth_strap(pll), .power_good_down_input(pwr),
    .slave_addr_strap_low(a_lo), .slave_addr_strap_high(a_hi),
    .freq_is_100m(f100), .pll_mode(pll_mode), .power_active(pa),
    .slave_addr(slave_addr), .read_length(read_length)
  );
  sbc_host host (.clk(clk), .sda_w(sda_w), .scl(scl), .sda(sda_h));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string n, input logic [7:0] s, e);
    samples_checked++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : wrap_up
  task automatic do_reset(input logic f, input logic [1:0] p, lo, hi);
    rst_n <= 1'b0;
    freq <= f;
    pll <= p;
    a_lo <= lo;
    a_hi <= hi;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : do_reset
  task automatic xb(input logic [7:0] d);
    logic a;
    host.wbyte(d, a);
    check("ack", 8'(a), 8'h01);
  endtask : xb
  task automatic head(input logic [7:0] cmd, input logic rd_back);
    host.start();
    xb({dev_addr, 1'b0});
    xb(cmd);
    if (rd_back) begin
      host.start();
      xb({dev_addr, 1'b1});
    end
  endtask : head
  task automatic rd(input logic [6:0] i, input logic [7:0] e);
    logic [7:0] d;
    head({1'b1, i}, 1'b1);
    host.rbyte(1'b1, d);
    host.stop();
    check("reg", d, e);
  endtask : rd
  task automatic wr(input logic [6:0] i, input logic [7:0] d);
    head({1'b1, i}, 1'b0);
    xb(d);
    host.stop();
  endtask : wr
  task automatic t_straps();
    for (int k = 0; k < 3; k++) begin
      do_reset(k[0], 2'(k), 2'(k), 2'(2 - k));
      dev_addr = 7'(8'h68 + 3 * (2 - k) + k);
      check("freq", 8'(f100), 8'(k[0]));
      check("pll", 8'(pll_mode), 8'(k));
      check("addr", 8'(slave_addr), 8'(dev_addr));
      check("len", 8'(read_length), 8'h08);
      rd(7'h07, 8'h08);
    end
    $display("test straps done");
  endtask : t_straps
  task automatic t_regs();
    rd(7'h05, 8'h3A);
    rd(7'h06, 8'h5C);
    wr(7'h05, 8'hFF);
    wr(7'h06, 8'h00);
    wr(7'h07, 8'hFF);
    rd(7'h05, 8'h3A);
    rd(7'h06, 8'h5C);
    rd(7'h07, 8'h1F);
    rd(7'h10, 8'h00);
    check("len", 8'(read_length), 8'h1F);
    check("oe_n", 8'(sda_oe_n), 8'h01);
    check("sda_o", 8'(sda_o), 8'h00);
    $display("test registers done");
  endtask : t_regs
  task automatic t_block();
    logic [7:0] d;
    logic [7:0] e[4] = '{8'h03, 8'h3A, 8'h5C, 8'h03};
    wr(7'h07, 8'h03);
    head(8'h05, 1'b1);
    for (int k = 0; k < 4; k++) begin
      host.rbyte(k == 3, d);
      check("blk", d, e[k]);
    end
    host.stop();
    head(8'h07, 1'b0);
    xb(8'h01);
    xb(8'h00);
    host.stop();
    check("len", 8'(read_length), 8'h00);
    head(8'h06, 1'b1);
    host.rbyte(1'b0, d);
    check("cnt", d, 8'h01);
    host.rbyte(1'b1, d);
    check("blk", d, 8'h5C);
    host.stop();
    $display("test block done");
  endtask : t_block
  task automatic wait_pa(input logic v);
    int n = 0;
    while (pa !== v && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("power", 8'(pa), 8'(v));
    if (pa !== v) wrap_up();
  endtask : wait_pa
  task automatic t_misc();
    logic a;
    host.start();
    host.wbyte({dev_addr ^ 7'h01, 1'b0}, a);
    host.stop();
    check("nak", 8'(a), 8'h00);
    pwr <= 1'b0;
    wait_pa(1'b0);
    pwr <= 1'b1;
    wait_pa(1'b1);
    $display("test misc done");
  endtask : t_misc
  initial begin
    rst_n = 1'b0;
    freq = 1'b0;
    pwr = 1'b1;
    pll = 2'h0;
    a_lo = 2'h0;
    a_hi = 2'h0;
    @(posedge clk);
    t_straps();
    t_regs();
    t_block();
    t_misc();
    wrap_up();
  end
  initial begin
    #500000;
    $display("timeout");
    mismatches++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
